// *** uxs_pkg.sv ***
// Package with register map, field positions, modes and carrier types of the serial port block.
package uxs_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] A_ERR_IE = 4'h0;
  localparam logic [3:0] A_GIR = 4'h1;
  localparam logic [3:0] A_FIFO = 4'h2;
  localparam logic [3:0] A_BRGL = 4'h3;
  localparam logic [3:0] A_BRGH = 4'h4;
  localparam logic [3:0] A_RXD = 4'h5;
  localparam logic [3:0] A_TXD = 4'h6;
  localparam logic [3:0] A_P1L = 4'h7;
  localparam logic [3:0] A_P2 = 4'h8;
  localparam logic [3:0] A_CTRL = 4'h9;
  localparam logic [3:0] A_MODE = 4'ha;

  // Field positions.
  localparam int GIR_WAKE = 7;
  localparam int GIR_ABD = 6;
  localparam int GIR_AUTOBAUD_DONE_IRQ_EN = 2;
  localparam int FS_TX_WRITE_ERROR = 7;
  localparam int FS_STOP_DETECT_MODE = 6;
  localparam int FS_TX_BUFFER_EMPTY = 5;
  localparam int FS_TX_BUFFER_FULL = 4;
  localparam int FS_RX_LINE_IDLE = 3;
  localparam int FS_XON = 2;
  localparam int FS_RX_BUFFER_EMPTY = 1;
  localparam int FS_RX_BUFFER_FULL = 0;
  localparam int CT_ON = 7;
  localparam int CT_WUE = 4;
  localparam int CT_BAUD_SPEED_SELECT = 3;

  // Mode codes and stop setting.
  localparam logic [3:0] MODE_ADDR = 4'h4;
  localparam logic [3:0] MODE_LIN_RESP = 4'hb;
  localparam logic [3:0] MODE_LIN_MST = 4'hc;
  localparam logic [3:0] MODE_LIGHT_DEV = 4'h8;
  localparam logic [3:0] MODE_LIGHT_GEAR = 4'h9;
  localparam logic [1:0] STOP_TWO_FIRST = 2'h3;

  // Buffer depth and baud clocks per bit.
  localparam int DEPTH = 2;
  localparam logic [1:0] DEPTH_CNT = 2'h2;
  localparam int BCLK_HS = 4;
  localparam int BCLK_NS = 16;
  localparam logic [3:0] SUB_LAST_HS = 4'(BCLK_HS - 1);
  localparam logic [3:0] SUB_LAST_NS = 4'(BCLK_NS - 1);

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_DIV = 16'h0000;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uxs_bus_s;

  // Events and levels from the framing engines.
  typedef struct packed {
    logic [7:0] err_flags;
    logic abd_done;
    logic rx_busy;
    logic flow_ok;
    logic master_active;
    logic addr_taken;
    logic break_seen;
    logic stop_mid_first;
    logic stop_end_first;
    logic stop_end_last;
    logic tx_take;
    logic rx_valid;
    logic [7:0] rx_byte;
  } uxs_evt_s;

  // Configuration handed to the framing engines.
  typedef struct packed {
    logic on;
    logic [3:0] mode;
    logic [1:0] stop_set;
    logic baud_speed;
    logic [15:0] div;
  } uxs_cfg_s;

  // Whole state of the register block.
  typedef struct packed {
    logic [2:0] rx_sync;
    logic rx_lvl;
    logic [7:0] err_en;
    logic wake;
    logic abd;
    logic abd_ie;
    logic wake_on_rx_enable;
    logic on;
    logic baud_speed;
    logic [3:0] mode;
    logic [1:0] stop_set;
    logic stop_mode;
    logic tx_wr_err;
    logic [DEPTH-1:0][7:0] tx_mem;
    logic tx_rd;
    logic tx_wr;
    logic [1:0] tx_cnt;
    logic [DEPTH-1:0][7:0] rx_mem;
    logic rx_rd;
    logic rx_wr;
    logic [1:0] rx_cnt;
    logic [15:0] div;
    logic [7:0] p1l;
    logic [7:0] p2;
    logic addr_pend;
    logic [7:0] lin_cnt;
    logic [15:0] brg_cnt;
    logic [3:0] sub;
    logic baud_tick;
    logic bit_tick;
    logic rx_irq;
    logic tx_flush;
    logic rx_idle;
    logic flow_tx_allowed;
    logic err_irq;
    logic port_irq;
    logic [7:0] rdata;
  } uxs_st_s;

endpackage

// *** uxs_regs.sv ***
// Status, interrupt, buffer and baud divisor registers of the multi-mode serial port.
// Overview of operation
// - Eight read/write error interrupt enables, one per error flag, reset to zero.
// - With wake enabled, receive line falling sets wake flag and combined interrupt.
// - Auto-baud done flag sets on completion and stays until software clears it.
// - Auto-baud interrupt enable routes the done flag onto the combined interrupt.
// - Bus master mode: writing parameter one while frame active sets write error.
// - Responder mode: transmit write with zero count or beyond count sets write error.
// - Address mode: rewriting address before shifter takes it sets write error.
// - Transmit write into a full buffer sets write error; only software clears it.
// - Stop detect mode selects mid first stop or end of stop for receive interrupt.
// - Transmit empty resets to one; writing one flushes buffer and shifter.
// - Read-only transmit full bit is one when the buffer is full.
// - Receive idle bit reads one while no receive sequence is in progress.
// - Read-only flow control bit shows whether transmitter may send; resets to one.
// - Receive empty resets to one; writing one flushes the receive buffer.
// - Read-only receive full bit is one when no receive entry is free.
// - Sixteen bit baud divisor in low and high byte registers, reset zero.
// - Reading receive data returns the oldest byte of the receive buffer.
// - Baud speed select gives four baud clocks per bit, else sixteen.
// - Mode codes 1000 and 1001 select the two lighting control modes.
// - Wake enable waits for falling edge and is cleared by hardware on wake.
`timescale 1ns/1ps

module uxs_regs
  import uxs_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Register port.
  input wire uxs_bus_s bus,
  output logic [7:0] rdata,
  // Receive pin.
  input wire logic rx_pin,
  // Framing engine events and configuration.
  input wire uxs_evt_s evt,
  output uxs_cfg_s cfg,
  // Transmit buffer head toward the shifter.
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_flush,
  // Receive buffer space.
  output logic rx_ready,
  // Baud enables.
  output logic baud_tick,
  output logic bit_tick,
  // Interrupts.
  output logic receive_irq,
  output logic port_combined_irq,
  output logic error_irq
);

  logic [1:0] rst_sync_q;
  logic rst_n;
  uxs_st_s s_q;
  uxs_st_s s_d;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  logic fall;
  logic [7:0] rd_mux;

  // The asynchronous reset is released through two flops so every flop leaves reset together.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Read multiplexer; unused addresses and unimplemented bits read zero.
  always_comb begin
    rd_mux = 8'h00;
    unique case (bus.addr)
      A_ERR_IE: rd_mux = s_q.err_en;
      A_GIR: begin
        rd_mux[GIR_WAKE] = s_q.wake;
        rd_mux[GIR_ABD] = s_q.abd;
        rd_mux[GIR_AUTOBAUD_DONE_IRQ_EN] = s_q.abd_ie;
      end
      A_FIFO: begin
        rd_mux[FS_TX_WRITE_ERROR] = s_q.tx_wr_err;
        rd_mux[FS_STOP_DETECT_MODE] = s_q.stop_mode;
        rd_mux[FS_TX_BUFFER_EMPTY] = (s_q.tx_cnt == 2'h0);
        rd_mux[FS_TX_BUFFER_FULL] = (s_q.tx_cnt == DEPTH_CNT);
        rd_mux[FS_RX_LINE_IDLE] = s_q.rx_idle;
        rd_mux[FS_XON] = s_q.flow_tx_allowed;
        rd_mux[FS_RX_BUFFER_EMPTY] = (s_q.rx_cnt == 2'h0);
        rd_mux[FS_RX_BUFFER_FULL] = (s_q.rx_cnt == DEPTH_CNT);
      end
      A_BRGL: rd_mux = s_q.div[7:0];
      A_BRGH: rd_mux = s_q.div[15:8];
      A_RXD: rd_mux = s_q.rx_mem[s_q.rx_rd];
      A_P1L: rd_mux = s_q.p1l;
      A_P2: rd_mux = s_q.p2;
      A_CTRL: begin
        rd_mux[CT_ON] = s_q.on;
        rd_mux[CT_WUE] = s_q.wake_on_rx_enable;
        rd_mux[CT_BAUD_SPEED_SELECT] = s_q.baud_speed;
      end
      A_MODE: rd_mux = {2'h0, s_q.stop_set, s_q.mode};
      default: rd_mux = 8'h00;
    endcase
  end

  // Buffer handshakes; a bus write into a full transmit buffer is dropped.
  assign tx_push = bus.wr && (bus.addr == A_TXD) && (s_q.tx_cnt != DEPTH_CNT);
  assign tx_pop = evt.tx_take && (s_q.tx_cnt != 2'h0);
  assign rx_push = evt.rx_valid && (s_q.rx_cnt != DEPTH_CNT);
  assign rx_pop = bus.rd && (bus.addr == A_RXD) && (s_q.rx_cnt != 2'h0);

  // Falling edge of the filtered line; idle is high.
  assign fall = s_q.rx_lvl && (s_q.rx_sync[2:1] == 2'h0);

  // Next state of the whole block.
  always_comb begin
    s_d = s_q;
    s_d.baud_tick = 1'b0;
    s_d.bit_tick = 1'b0;
    s_d.rx_irq = 1'b0;
    s_d.tx_flush = 1'b0;
    // Pin synchroniser; a level counts once the second and third flops agree.
    s_d.rx_sync = {s_q.rx_sync[1:0], rx_pin};
    if (s_q.rx_sync[1] == s_q.rx_sync[2]) begin
      s_d.rx_lvl = s_q.rx_sync[2];
    end
    s_d.rx_idle = !evt.rx_busy && s_q.rx_lvl;
    s_d.flow_tx_allowed = evt.flow_ok;

    // Software writes come first so that hardware sets in the same cycle win.
    if (bus.wr) begin
      unique case (bus.addr)
        A_ERR_IE: s_d.err_en = bus.wdata;
        A_GIR: begin
          // Flags can only be cleared by software; writing one leaves them alone.
          if (!bus.wdata[GIR_WAKE]) s_d.wake = 1'b0;
          if (!bus.wdata[GIR_ABD]) s_d.abd = 1'b0;
          s_d.abd_ie = bus.wdata[GIR_AUTOBAUD_DONE_IRQ_EN];
        end
        A_FIFO: begin
          if (!bus.wdata[FS_TX_WRITE_ERROR]) s_d.tx_wr_err = 1'b0;
          s_d.stop_mode = bus.wdata[FS_STOP_DETECT_MODE];
        end
        A_BRGL: s_d.div[7:0] = bus.wdata;
        A_BRGH: s_d.div[15:8] = bus.wdata;
        A_TXD: begin
          if (s_q.tx_cnt == DEPTH_CNT) s_d.tx_wr_err = 1'b1;
          if (s_q.mode == MODE_LIN_RESP) begin
            if ((s_q.p2 == 8'h00) || (s_q.lin_cnt >= s_q.p2)) begin
              s_d.tx_wr_err = 1'b1;
            end
            if (s_q.lin_cnt != 8'hff) s_d.lin_cnt = s_q.lin_cnt + 8'h01;
          end
        end
        A_P1L: begin
          s_d.p1l = bus.wdata;
          if ((s_q.mode == MODE_LIN_MST) && evt.master_active) s_d.tx_wr_err = 1'b1;
          if ((s_q.mode == MODE_ADDR) && s_q.addr_pend) s_d.tx_wr_err = 1'b1;
        end
        A_P2: s_d.p2 = bus.wdata;
        A_CTRL: begin
          s_d.on = bus.wdata[CT_ON];
          s_d.wake_on_rx_enable = bus.wdata[CT_WUE];
          s_d.baud_speed = bus.wdata[CT_BAUD_SPEED_SELECT];
        end
        A_MODE: begin
          s_d.stop_set = bus.wdata[5:4];
          // The lighting codes pass to the engines like any other mode code.
          s_d.mode = bus.wdata[3:0];
        end
        default: s_d.rdata = s_q.rdata;
      endcase
    end

    // Address pending: a fresh write wins over the shifter taking the old one.
    if (evt.addr_taken) s_d.addr_pend = 1'b0;
    if (bus.wr && (bus.addr == A_P1L)) s_d.addr_pend = 1'b1;

    // A break restarts the responder byte count.
    if (evt.break_seen) s_d.lin_cnt = 8'h00;

    // Wake on the first falling edge, then the enable drops by itself.
    if (s_q.wake_on_rx_enable && fall) begin
      s_d.wake = 1'b1;
      s_d.wake_on_rx_enable = 1'b0;
    end
    if (evt.abd_done) s_d.abd = 1'b1;

    // Transmit buffer: write at the tail, the shifter takes the head.
    if (tx_push) begin
      s_d.tx_mem[s_q.tx_wr] = bus.wdata;
      s_d.tx_wr = !s_q.tx_wr;
    end
    if (tx_pop) s_d.tx_rd = !s_q.tx_rd;
    s_d.tx_cnt = s_q.tx_cnt + {1'b0, tx_push} - {1'b0, tx_pop};

    // Receive buffer: the engine fills, a data read drains.
    if (rx_push) begin
      s_d.rx_mem[s_q.rx_wr] = evt.rx_byte;
      s_d.rx_wr = !s_q.rx_wr;
    end
    if (rx_pop) s_d.rx_rd = !s_q.rx_rd;
    s_d.rx_cnt = s_q.rx_cnt + {1'b0, rx_push} - {1'b0, rx_pop};

    // Flushes win over traffic in the same cycle; a whole-register write with zero
    // in the transmit empty position leaves the transmit side alone.
    if (bus.wr && (bus.addr == A_FIFO) && bus.wdata[FS_TX_BUFFER_EMPTY]) begin
      s_d.tx_cnt = 2'h0;
      s_d.tx_rd = 1'b0;
      s_d.tx_wr = 1'b0;
      s_d.tx_flush = 1'b1;
    end
    if (bus.wr && (bus.addr == A_FIFO) && bus.wdata[FS_RX_BUFFER_EMPTY]) begin
      s_d.rx_cnt = 2'h0;
      s_d.rx_rd = 1'b0;
      s_d.rx_wr = 1'b0;
    end

    // Receive interrupt timing chosen by stop detect mode.
    if (!s_q.stop_mode) begin
      s_d.rx_irq = evt.stop_mid_first;
    end else if (s_q.stop_set == STOP_TWO_FIRST) begin
      s_d.rx_irq = evt.stop_end_first;
    end else begin
      s_d.rx_irq = evt.stop_end_last;
    end

    // Baud generator: one baud clock every divisor plus one cycles, held off while disabled.
    // The divisor is not range checked; software keeps within the lighting-mode limits.
    if (s_q.on) begin
      if (s_q.brg_cnt == s_q.div) begin
        s_d.brg_cnt = 16'h0000;
        s_d.baud_tick = 1'b1;
        if (s_q.sub == (s_q.baud_speed ? SUB_LAST_HS : SUB_LAST_NS)) begin
          s_d.sub = 4'h0;
          s_d.bit_tick = 1'b1;
        end else begin
          s_d.sub = s_q.sub + 4'h1;
        end
      end else begin
        s_d.brg_cnt = s_q.brg_cnt + 16'h0001;
      end
    end else begin
      s_d.brg_cnt = 16'h0000;
      s_d.sub = 4'h0;
    end

    // Interrupt levels, registered so they leave the block glitch free.
    s_d.err_irq = |(evt.err_flags & s_q.err_en);
    s_d.port_irq = s_d.wake || (s_d.abd && s_d.abd_ie);

    // Read data stands in the cycle after the strobe.
    s_d.rdata = bus.rd ? rd_mux : 8'h00;
  end

  // State register with reset values.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.rx_sync <= 3'h7;
      s_q.rx_lvl <= 1'b1;
      s_q.rx_idle <= 1'b1;
      s_q.flow_tx_allowed <= 1'b1;
      s_q.div <= RST_DIV;
      s_q.rdata <= RST_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs.
  assign rdata = s_q.rdata;
  assign cfg = '{on: s_q.on, mode: s_q.mode, stop_set: s_q.stop_set,
                 baud_speed: s_q.baud_speed, div: s_q.div};
  assign tx_data = s_q.tx_mem[s_q.tx_rd];
  assign tx_valid = (s_q.tx_cnt != 2'h0);
  assign tx_flush = s_q.tx_flush;
  assign rx_ready = (s_q.rx_cnt != DEPTH_CNT);
  assign baud_tick = s_q.baud_tick;
  assign bit_tick = s_q.bit_tick;
  assign receive_irq = s_q.rx_irq;
  assign port_combined_irq = s_q.port_irq;
  assign error_irq = s_q.err_irq;

endmodule // uxs_regs

// *** uxs_regs_props.sv ***
// Checker of the serial port register block, bound to its ports.
`timescale 1ns/1ps
module uxs_regs_props
  import uxs_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Requests and events.
  input wire uxs_bus_s bus,
  input wire uxs_evt_s evt,
  // Outputs under watch.
  input wire logic [7:0] rdata,
  input wire logic tx_valid,
  input wire logic tx_flush,
  input wire logic rx_ready,
  input wire logic baud_tick,
  input wire logic bit_tick,
  input wire logic receive_irq,
  input wire logic port_combined_irq,
  input wire logic error_irq
);
  logic gir_wr_q;
  logic stop_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Remember last cycle's flag clear and stop event, so the irq lag is allowed for.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gir_wr_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      gir_wr_q <= bus.wr && bus.addr == A_GIR;
      stop_q <= evt.stop_mid_first || evt.stop_end_first || evt.stop_end_last;
    end
  end

  chk_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  chk_tx_flush: assert property (bus.wr && bus.addr == A_FIFO && bus.wdata[FS_TX_BUFFER_EMPTY]
    |=> tx_flush && !tx_valid)
    else $error("transmit flush missing");
  chk_tx_push: assert property (bus.wr && bus.addr == A_TXD && !tx_valid |=> tx_valid)
    else $error("queued byte not shown");
  chk_rx_space: assert property (bus.wr && bus.addr == A_FIFO && bus.wdata[FS_RX_BUFFER_EMPTY]
    |=> rx_ready)
    else $error("receive flush left no space");
  chk_err_quiet: assert property ($past(evt.err_flags) == 8'h00 |-> !error_irq)
    else $error("error irq without a flag");
  chk_rx_irq_cause: assert property (!stop_q |-> !receive_irq)
    else $error("receive irq without stop event");
  chk_irq_holds: assert property (port_combined_irq && !gir_wr_q
    && !(bus.wr && bus.addr == A_GIR) |=> port_combined_irq)
    else $error("port irq dropped without a clear");
  chk_bit_on_baud: assert property (bit_tick |-> baud_tick)
    else $error("bit tick off a baud tick");
endmodule // uxs_regs_props

bind uxs_regs uxs_regs_props i_uxs_regs_props (.mclk(mclk), .arst_n(arst_n), .bus(bus),
  .evt(evt), .rdata(rdata), .tx_valid(tx_valid), .tx_flush(tx_flush), .rx_ready(rx_ready),
  .baud_tick(baud_tick), .bit_tick(bit_tick), .receive_irq(receive_irq),
  .port_combined_irq(port_combined_irq), .error_irq(error_irq));

// *** uxs_node.sv ***
// Remote serial node: pulls the receive line low and takes transmit bytes slowly.
`timescale 1ns/1ps
module uxs_node (
  // Clock.
  input wire logic mclk,
  // Commands from the bench.
  input wire logic take_en,
  input wire logic send_low,
  input wire logic [7:0] low_len,
  // Transmit buffer head.
  input wire logic tx_valid,
  // Line and shifter side.
  output logic rx_pin,
  output logic tx_take
);
  logic [7:0] low_cnt = 8'h00;
  logic [1:0] wait_cnt = 2'h0;
  logic take_q = 1'b0;

  // A take every fifth cycle, so the buffer sees a slow shifter.
  always_ff @(posedge mclk) begin
    take_q <= 1'b0;
    if (take_en && tx_valid && !take_q) begin
      wait_cnt <= wait_cnt + 2'h1;
      take_q <= (wait_cnt == 2'h3);
    end
    if (send_low) begin
      low_cnt <= low_len;
    end else if (low_cnt != 8'h00) begin
      low_cnt <= low_cnt - 8'h01;
    end
  end

  // Line idles high, so it returns high once the low period runs out.
  assign rx_pin = (low_cnt == 8'h00);
  assign tx_take = take_q;
endmodule // uxs_node

// *** uxs_regs_tb_top.sv ***
// Self-checking testbench of the serial port register block.
`timescale 1ns/1ps
module uxs_regs_tb_top;
  import uxs_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  uxs_bus_s bus_q = '0;
  uxs_evt_s ev_q = '0;
  uxs_evt_s evt;
  uxs_cfg_s cfg;
  logic [7:0] rdata, tx_data;
  logic [7:0] low_len = 8'h08;
  logic rx_pin, tx_valid, tx_flush, rx_ready, baud_tick, bit_tick, take;
  logic receive_irq, port_combined_irq, error_irq;
  logic take_en = 1'b0;
  logic send_low = 1'b0;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;

  // Shifter takes come from the node, all other events from the bench.
  always_comb begin
    evt = ev_q;
    evt.tx_take = take;
  end

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  uxs_regs i_uxs_regs (.mclk(mclk), .arst_n(arst_n), .bus(bus_q), .rdata(rdata),
    .rx_pin(rx_pin), .evt(evt), .cfg(cfg), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_flush(tx_flush), .rx_ready(rx_ready), .baud_tick(baud_tick), .bit_tick(bit_tick),
    .receive_irq(receive_irq), .port_combined_irq(port_combined_irq), .error_irq(error_irq));
  uxs_node i_uxs_node (.mclk(mclk), .take_en(take_en), .send_low(send_low),
    .low_len(low_len), .tx_valid(tx_valid), .rx_pin(rx_pin), .tx_take(take));

  task automatic give_verdict();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Each access leaves one idle edge behind it, so strobes never rise twice in a step.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_q.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    bus_q <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_q.rd <= 1'b0;
    @(negedge mclk);
    cmp(rdata, e);
  endtask

  task automatic abd_pulse(input logic [7:0] e);
    @(posedge mclk);
    ev_q.abd_done <= 1'b1;
    @(posedge mclk);
    ev_q.abd_done <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    cmp({7'h00, port_combined_irq}, e);
  endtask

  task automatic stop_pulse(input int k, input logic [7:0] e);
    @(posedge mclk);
    ev_q.stop_mid_first <= (k == 0);
    ev_q.stop_end_first <= (k == 1);
    ev_q.stop_end_last <= (k == 2);
    @(posedge mclk);
    {ev_q.stop_mid_first, ev_q.stop_end_first, ev_q.stop_end_last} <= 3'h0;
    @(negedge mclk);
    cmp({7'h00, receive_irq}, e);
  endtask

  task automatic t_regs();
    rd(A_FIFO, 8'h2e);
    rd(A_GIR, 8'h00);
    rd(A_BRGH, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rd(A_ERR_IE, 8'h00);
      wr(A_ERR_IE, 8'h01 << i);
      rd(A_ERR_IE, 8'h01 << i);
      ev_q.err_flags <= ~(8'h01 << i);
      repeat (2) @(posedge mclk);
      ev_q.err_flags <= 8'h01 << i;
      @(negedge mclk);
      cmp({7'h00, error_irq}, 8'h00);
      @(posedge mclk);
      ev_q.err_flags <= 8'h00;
      @(negedge mclk);
      cmp({7'h00, error_irq}, 8'h01);
      wr(A_ERR_IE, 8'h00);
    end
    wr(A_GIR, 8'hff);
    rd(A_GIR, 8'h04);
    wr(A_GIR, 8'h00);
    rd(4'hf, 8'h00);
    wr(A_BRGL, 8'h03);
    wr(A_BRGH, 8'h5a);
    rd(A_BRGH, 8'h5a);
    cmp(cfg.div[15:8], 8'h5a);
    wr(A_BRGH, 8'h00);
    rd(A_BRGL, 8'h03);
    cmp(cfg.div[7:0], 8'h03);
  endtask

  // High speed first, then normal speed, both with a divisor of three.
  task automatic t_baud();
    int n;
    for (int m = 0; m < 2; m++) begin
      wr(A_CTRL, (m == 0) ? 8'h88 : 8'h80);
      n = 0;
      while (!bit_tick && n < 99) begin
        @(negedge mclk);
        n++;
      end
      @(negedge mclk);
      n = 1;
      while (!bit_tick && n < 99) begin
        @(negedge mclk);
        n++;
      end
      cmp(8'(n), (m == 0) ? 8'h10 : 8'h40);
      wr(A_CTRL, 8'h00);
    end
  endtask

  task automatic t_tx();
    wr(A_TXD, 8'ha1);
    wr(A_TXD, 8'hb2);
    rd(A_FIFO, 8'h1e);
    wr(A_TXD, 8'hc3);
    rd(A_FIFO, 8'h9e);
    wr(A_FIFO, 8'h20);
    rd(A_FIFO, 8'h2e);
    wr(A_TXD, 8'ha1);
    wr(A_TXD, 8'hb2);
    take_en <= 1'b1;
    for (int k = 0; k < 20 && !take; k++) @(negedge mclk);
    cmp(tx_data, 8'ha1);
    @(negedge mclk);
    cmp(tx_data, 8'hb2);
    for (int k = 0; k < 20 && tx_valid; k++) @(negedge mclk);
    rd(A_FIFO, 8'h2e);
    take_en <= 1'b0;
  endtask

  task automatic t_rx();
    @(posedge mclk);
    ev_q.rx_valid <= 1'b1;
    ev_q.rx_byte <= 8'h11;
    @(posedge mclk);
    ev_q.rx_byte <= 8'h22;
    @(posedge mclk);
    {ev_q.rx_valid, ev_q.rx_busy, ev_q.flow_ok} <= 3'b010;
    rd(A_FIFO, 8'h21);
    {ev_q.rx_busy, ev_q.flow_ok} <= 2'b01;
    rd(A_RXD, 8'h11);
    rd(A_RXD, 8'h22);
    ev_q.rx_valid <= 1'b1;
    @(posedge mclk);
    ev_q.rx_valid <= 1'b0;
    rd(A_FIFO, 8'h2c);
    wr(A_FIFO, 8'h02);
    rd(A_FIFO, 8'h2e);
  endtask

  task automatic t_irq();
    wr(A_CTRL, 8'h10);
    send_low <= 1'b1;
    @(posedge mclk);
    send_low <= 1'b0;
    for (int k = 0; k < 20 && !port_combined_irq; k++) @(negedge mclk);
    cmp({7'h00, port_combined_irq}, 8'h01);
    rd(A_GIR, 8'h80);
    rd(A_CTRL, 8'h00);
    wr(A_GIR, 8'h00);
    abd_pulse(8'h00);
    rd(A_GIR, 8'h40);
    wr(A_GIR, 8'hc4);
    rd(A_GIR, 8'h44);
    cmp({7'h00, port_combined_irq}, 8'h01);
    wr(A_GIR, 8'h00);
    abd_pulse(8'h00);
    wr(A_GIR, 8'h04);
    abd_pulse(8'h01);
    wr(A_GIR, 8'h00);
  endtask

  task automatic t_err_modes();
    wr(A_MODE, {4'h0, MODE_LIN_MST});
    ev_q.master_active <= 1'b1;
    wr(A_P1L, 8'h5a);
    ev_q.master_active <= 1'b0;
    rd(A_FIFO, 8'hae);
    wr(A_FIFO, 8'h00);
    {ev_q.addr_taken, ev_q.break_seen} <= 2'b11;
    wr(A_MODE, {4'h0, MODE_ADDR});
    {ev_q.addr_taken, ev_q.break_seen} <= 2'b00;
    wr(A_P1L, 8'h01);
    rd(A_FIFO, 8'h2e);
    wr(A_P1L, 8'h02);
    rd(A_FIFO, 8'hae);
    wr(A_MODE, {4'h0, MODE_LIN_RESP});
    wr(A_P2, 8'h01);
    wr(A_FIFO, 8'h00);
    wr(A_TXD, 8'h77);
    rd(A_FIFO, 8'h0e);
    wr(A_TXD, 8'h78);
    rd(A_FIFO, 8'h9e);
    wr(A_FIFO, 8'h40);
    wr(A_MODE, 8'h00);
    stop_pulse(0, 8'h00);
    stop_pulse(2, 8'h01);
    wr(A_MODE, 8'h30);
    stop_pulse(1, 8'h01);
    wr(A_FIFO, 8'h20);
    stop_pulse(0, 8'h01);
    wr(A_MODE, {4'h0, MODE_LIGHT_DEV});
    rd(A_MODE, 8'h08);
    wr(A_MODE, {4'h0, MODE_LIGHT_GEAR});
    @(negedge mclk);
    cmp({4'h0, cfg.mode}, 8'h09);
  endtask

  // Cut a hang short well past the few hundred cycles the run needs.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    ev_q.flow_ok <= 1'b1;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_regs();
    t_baud();
    t_tx();
    t_rx();
    t_irq();
    t_err_modes();
    give_verdict();
  end
endmodule // uxs_regs_tb_top
